// ===== hdl/adm_pkg.sv
// shared constants and types for the alarm, dial-out and error monitor
`default_nettype none
package adm_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_SEC = 1_000_000_000;
  localparam int TICK_CYCLES_DFLT = NS_PER_SEC / CLK_PERIOD_NS;
  localparam logic [9:0] SEC_PER_MIN = 10'h03c;
  localparam logic [3:0] DLY_MIN = 4'h1;
  localparam logic [3:0] DLY_MAX = 4'ha;

  // call retry and trap queue
  localparam logic [2:0] MAX_RETRY = 3'h5;
  localparam int TRAP_QUEUE_DEPTH = 10;

  // error rate windows in seconds and thresholds in crc6 errors
  localparam logic [9:0] WIN_SHORT = 10'h00a;
  localparam logic [9:0] WIN_LONG = 10'h03c;
  localparam logic [9:0] WIN_15MIN = 10'h384;
  localparam logic [13:0] THR_E4 = 14'h05ff;
  localparam logic [13:0] THR_E5 = 14'h0399;
  localparam logic [13:0] THR_E6 = 14'h005c;
  localparam logic [13:0] THR_E7 = 14'h0009;
  localparam logic [13:0] THR_E8 = 14'h0029;
  localparam logic [13:0] THR_E9 = 14'h0004;
  localparam logic [11:0] CNT_SAT = 12'hfff;

  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [31:0] CFG_MASK = 32'h0007_ffff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0520;

  // command register bit positions
  localparam int CMD_PRIO_LSB = 0;
  localparam int CMD_OWN_TRAP = 8;
  localparam int CMD_FWD_TRAP = 9;
  localparam int CMD_CUTOFF = 10;
  localparam int CMD_DISC = 11;

  // alarm message routing
  typedef enum logic [1:0] {
    ROUTE_NONE = 2'h0,
    ROUTE_MODEM = 2'h1,
    ROUTE_COM = 2'h2,
    ROUTE_BOTH = 2'h3
  } adm_route_t;

  // dial-out sequencer, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DIAL = 4'h2,
    ST_WAIT = 4'h4,
    ST_CONN = 4'h8
  } adm_call_st_t;

  // configuration register layout
  typedef struct packed {
    logic [12:0] rsvd;
    logic shared_relay_enable;
    logic [2:0] err_sel;
    logic [2:0] backup_directory_select;
    logic [3:0] dial_delay_min;
    logic retry_enable;
    logic auto_call_enable;
    logic trap_hangup;
    logic carrier_unit;
    logic trap_send_enable;
    logic com_ascii;
    adm_route_t route;
  } adm_cfg_t;

  // line conditions from the framers
  typedef struct packed {
    logic signal_loss_net;
    logic framing_loss_net;
    logic signal_loss_di;
    logic framing_loss_di;
    logic framing_loss_port;
    logic all_ones_indication;
    logic yellow_alarm;
  } adm_line_t;

  // status register layout
  typedef struct packed {
    logic [3:0] rsvd;
    adm_line_t line;
    logic link_up;
    adm_call_st_t state;
    logic on_backup;
    logic [2:0] retries;
    logic [3:0] trap_count;
    logic [3:0] held_prio;
    logic cutoff;
    logic relay;
    logic [1:0] excessive_error_condition;
  } adm_stat_t;

endpackage
`default_nettype wire

// ===== hdl/adm_eer.sv
// excessive error rate detector for one crc6 error stream
`default_nettype none
module adm_eer (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // one-second tick and error pulse, both on clk
  input wire logic tick,
  input wire logic err,
  input wire logic [2:0] sel,
  // declared condition
  output logic eer
);
  import adm_pkg::*;

  typedef struct packed {
    logic [9:0] sec;
    logic [11:0] cur;
    logic [11:0] p1;
    logic [11:0] p2;
    logic eer;
  } adm_eer_st_t;

  adm_eer_st_t s, n;
  logic [9:0] win;
  logic [13:0] thr;
  logic [11:0] cur_inc;
  logic [13:0] sum;

  // window length and threshold per rate setting
  always_comb begin
    unique case (sel)
      3'h1: begin win = WIN_LONG; thr = THR_E5; end // [R17]
      3'h2: begin win = WIN_LONG; thr = THR_E6; end // [R17]
      3'h3: begin win = WIN_LONG; thr = THR_E7; end // [R18]
      3'h4: begin win = WIN_15MIN; thr = THR_E8; end // [R19]
      3'h5: begin win = WIN_15MIN; thr = THR_E9; end // [R19]
      default: begin win = WIN_SHORT; thr = THR_E4; end // [R16]
    endcase
  end

  // count saturates so a burst cannot wrap below the threshold
  assign cur_inc = (err && s.cur != CNT_SAT) ? s.cur + 12'h001 : s.cur;
  // only the 15-minute settings look back over three intervals
  assign sum = (win == WIN_15MIN) ? 14'(cur_inc) + 14'(s.p1) + 14'(s.p2) : 14'(cur_inc); // [R19]

  always_comb begin
    n = s;
    n.cur = cur_inc;
    if (sum > thr) begin
      n.eer = 1'b1; // [R23]
    end
    if (tick) begin
      if (s.sec + 10'h001 >= win) begin
        // window closes: judge it, then restart the count
        n.eer = (sum > thr); // [R23]
        n.p2 = s.p1;
        n.p1 = cur_inc;
        n.cur = '0; // [R23]
        n.sec = '0;
      end else begin
        n.sec = s.sec + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign eer = s.eer;
endmodule // adm_eer
`default_nettype wire

// ===== hdl/adm_top.sv
// alarm routing, trap gating, dial-out sequencing, error rate and relay control
//
// Overview of operation
// R1 - alarm messages go to none, modem, com port, or both.
// R2 - com port alarm messages only when the com port is in ascii use.
// R3 - own traps are sent only while trap sending is enabled.
// R4 - carrier unit with traps off still forwards traps from other units.
// R5 - trap hang-up on releases a trap-opened call once traps are sent.
// R6 - auto calling with no link: pending alarm or trap dials alarm directory.
// R7 - failed call holds pending alarm or trap until connected or retries exhausted.
// R8 - while awaiting retry only the highest priority alarm is kept.
// R9 - up to ten trap messages are queued for the modem link.
// R10 - auto calling off and no link: traps queue, alarms are dropped.
// R11 - retry on: at most five reattempts, dial delay between attempts.
// R12 - retry off: exactly one call attempt.
// R13 - dial delay of one to ten minutes, default five.
// R14 - backup directory: five retries on primary, then backup with five retries.
// R15 - each new event starts dialing at the alarm directory.
// R16 - 1e-4: more than 1535 crc6 errors in 10 seconds.
// R17 - 1e-5 and 1e-6: more than 921 or 92 errors in 60 seconds.
// R18 - 1e-7: more than 9 errors in 60 seconds.
// R19 - 1e-8 and 1e-9: more than 41 or 4 over three 15-minute intervals.
// R20 - relay enabled: any alarm drives relay; release when all clear.
// R21 - cut-off releases relay until every alarm condition has cleared.
// R22 - relay causes: signal or framing loss, all-ones, yellow, excessive errors.
// R23 - error count restarts each window; judged at close or on overflow.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`default_nettype none
module adm_top #(
  parameter int TICK_CYCLES = adm_pkg::TICK_CYCLES_DFLT,
  parameter int QUEUE_DEPTH = adm_pkg::TRAP_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone classic slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // line interface conditions, asynchronous
  input wire adm_pkg::adm_line_t line_cond,
  input wire logic [1:0] crc_err,
  // modem or external communication device, asynchronous inputs
  input wire logic link_up,
  input wire logic call_fail,
  output logic call_req,
  output logic [2:0] call_dir,
  output logic hangup,
  // message strobes
  output logic alarm_modem,
  output logic alarm_com,
  output logic trap_send,
  output logic trap_fwd,
  // shared carrier relay
  output logic relay
);
  import adm_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES);

  // refuse settings the counters cannot hold
  if (TICK_CYCLES < 2) begin : g_chk_tick
    $error("adm_top: TICK_CYCLES must be at least 2");
  end
  if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > 15) begin : g_chk_q
    $error("adm_top: QUEUE_DEPTH must be 1 to 15");
  end

  typedef struct packed {
    adm_line_t l1;
    adm_line_t l2;
    logic [1:0] e1;
    logic [1:0] e2;
    logic [1:0] e3;
    logic f1;
    logic f2;
    logic f3;
    logic k1;
    logic k2;
    logic [PW-1:0] pre;
    logic [9:0] dly;
    adm_cfg_t cfg;
    adm_call_st_t st;
    logic [2:0] att;
    logic backup;
    logic [3:0] held;
    logic [3:0] q;
    logic trap_call;
    logic cutoff;
    logic ack;
    logic [31:0] dat;
    logic call_req;
    logic [2:0] dir;
    logic hang;
    logic alm_modem;
    logic alm_com;
    logic trap;
    logic fwd;
    logic relay;
  } adm_top_st_t;

  adm_top_st_t s, n;

  logic req;
  logic wr;
  logic tick;
  logic link;
  logic failp;
  logic [1:0] errp;
  logic [1:0] eer;
  logic any_alarm;
  logic [31:0] cfg_bits;
  adm_cfg_t cfg_new;
  logic cmd_wr;
  logic post_alarm;
  logic [3:0] prio;
  logic own_trap;
  logic fwd_trap;
  logic cut_cmd;
  logic disc_cmd;
  logic to_modem;
  logic to_com;
  logic hold_new;
  logic q_inc;
  logic q_dec;
  logic [3:0] q_nx;
  logic pending;
  logic [3:0] dmin;
  logic [9:0] dly_load;
  adm_stat_t stat;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  // ack is a registered one-cycle answer, so every access takes one wait
  assign req = wb_cyc & wb_stb & ~s.ack;
  assign wr = wb_cyc & wb_stb & wb_we & s.ack; // writes land at the ack edge
  assign cmd_wr = wr && wb_adr == OFS_CMD;
  assign prio = wb_dat_w[CMD_PRIO_LSB +: 4];
  assign post_alarm = cmd_wr && wb_sel[0] && prio != 4'h0;
  assign own_trap = cmd_wr & wb_sel[1] & wb_dat_w[CMD_OWN_TRAP];
  assign fwd_trap = cmd_wr & wb_sel[1] & wb_dat_w[CMD_FWD_TRAP];
  // cut-off as issued from the front_panel_unit for this unit
  assign cut_cmd = cmd_wr & wb_sel[1] & wb_dat_w[CMD_CUTOFF];
  assign disc_cmd = cmd_wr & wb_sel[1] & wb_dat_w[CMD_DISC];

  // configuration bytes follow their lane selects
  for (genvar b = 0; b < 4; b++) begin : g_cfg_lane
    assign cfg_bits[8*b +: 8] = (wr && wb_adr == OFS_CFG && wb_sel[b]) ? wb_dat_w[8*b +: 8] : s.cfg[8*b +: 8];
  end
  assign cfg_new = adm_cfg_t'(cfg_bits & CFG_MASK);

  ////////////////////////////////////////////////////////////////////////
  // synchronised pins and time base

  assign link = s.k2;
  // edge on the second stage against a third, never on the first
  assign failp = s.f2 & ~s.f3;
  assign errp = s.e2 & ~s.e3;
  assign tick = s.pre == PW'(TICK_CYCLES - 1);

  // delay setting outside one to ten is clamped rather than refused
  always_comb begin
    if (s.cfg.dial_delay_min < DLY_MIN) begin
      dmin = DLY_MIN;
    end else if (s.cfg.dial_delay_min > DLY_MAX) begin
      dmin = DLY_MAX;
    end else begin
      dmin = s.cfg.dial_delay_min;
    end
  end
  assign dly_load = 10'(dmin) * SEC_PER_MIN; // [R13]

  ////////////////////////////////////////////////////////////////////////
  // error rate, one detector per monitored interface

  for (genvar c = 0; c < 2; c++) begin : g_eer
    adm_eer u_eer (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .err(errp[c]),
      .sel(s.cfg.err_sel),
      .eer(eer[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // message routing and trap queue

  assign to_modem = post_alarm && (s.cfg.route == ROUTE_MODEM || s.cfg.route == ROUTE_BOTH); // [R1]
  assign to_com = post_alarm && (s.cfg.route == ROUTE_COM || s.cfg.route == ROUTE_BOTH) && s.cfg.com_ascii; // [R1] [R2]
  // with no link, a modem alarm is kept only if it can start a call
  assign hold_new = to_modem & ~link & s.cfg.auto_call_enable; // [R10]
  assign q_inc = own_trap && s.cfg.trap_send_enable && s.q < 4'(QUEUE_DEPTH); // [R3] [R9] [R10]
  assign q_dec = link && s.q != 4'h0 && s.cfg.trap_send_enable;
  assign q_nx = 4'(s.q + {3'h0, q_inc} - {3'h0, q_dec});
  assign pending = s.held != 4'h0 || s.q != 4'h0;

  // relay causes: line conditions and both error detectors
  assign any_alarm = (|s.l2) | (|eer); // [R22]

  always_comb begin
    stat = '0;
    stat.line = s.l2;
    stat.link_up = link;
    stat.state = s.st;
    stat.on_backup = s.backup;
    stat.retries = s.att;
    stat.trap_count = s.q;
    stat.held_prio = s.held;
    stat.cutoff = s.cutoff;
    stat.relay = s.relay;
    stat.excessive_error_condition = eer;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = s;
    // synchronisers
    n.l1 = line_cond;
    n.l2 = s.l1;
    n.e1 = crc_err;
    n.e2 = s.e1;
    n.e3 = s.e2;
    n.f1 = call_fail;
    n.f2 = s.f1;
    n.f3 = s.f2;
    n.k1 = link_up;
    n.k2 = s.k1;
    n.pre = tick ? '0 : s.pre + PW'(1);
    if (tick && s.dly != 10'h000) begin
      n.dly = s.dly - 10'h001;
    end
    // bus answer; unmapped reads give zero and writes are dropped
    n.ack = req;
    n.cfg = cfg_new;
    if (req && !wb_we) begin
      unique case (wb_adr)
        OFS_CFG: n.dat = 32'(s.cfg);
        OFS_STAT: n.dat = 32'(stat);
        default: n.dat = 32'h0000_0000;
      endcase
    end
    // strobes last one cycle
    n.alm_modem = 1'b0;
    n.alm_com = to_com; // [R2]
    n.trap = q_dec; // [R3]
    n.fwd = fwd_trap & (s.cfg.trap_send_enable | s.cfg.carrier_unit); // [R4]
    n.hang = disc_cmd;
    // modem alarm: straight out on a link, else held by priority when auto calling is on
    if (to_modem && link) begin
      n.alm_modem = 1'b1;
    end else if (link && s.held != 4'h0) begin
      n.alm_modem = 1'b1;
      n.held = 4'h0;
    end
    if (hold_new && prio >= s.held) begin
      n.held = prio; // [R7] [R8]
    end
    n.q = q_nx;
    // release a trap-opened call once nothing is left to send
    if (s.trap_call && link && q_nx == 4'h0 && s.held == 4'h0) begin
      n.trap_call = 1'b0;
      n.hang = disc_cmd | s.cfg.trap_hangup; // [R5]
    end
    // dial-out sequencer
    unique case (s.st)
      ST_IDLE: begin
        if (link) begin
          n.st = ST_CONN;
        end else if (s.cfg.auto_call_enable && pending && s.dly == 10'h000) begin
          n.st = ST_DIAL; // [R6]
          n.call_req = 1'b1;
          n.dir = 3'h0; // [R15]
          n.backup = 1'b0;
          n.att = 3'h0;
          n.trap_call = s.q != 4'h0;
        end
      end
      ST_DIAL: begin
        if (link) begin
          n.st = ST_CONN;
          n.call_req = 1'b0;
        end else if (failp) begin
          n.call_req = 1'b0;
          n.dly = dly_load; // [R11]
          if (s.cfg.retry_enable && s.att < MAX_RETRY) begin
            n.att = s.att + 3'h1; // [R11]
            n.st = ST_WAIT;
          end else if (s.cfg.retry_enable && !s.backup && s.cfg.backup_directory_select != 3'h0) begin
            n.backup = 1'b1; // [R14]
            n.att = 3'h0;
            n.dir = s.cfg.backup_directory_select;
            n.st = ST_WAIT;
          end else begin
            // retries spent or retry off: drop what was held
            n.st = ST_IDLE; // [R12]
            n.held = hold_new ? prio : 4'h0; // [R7]
            n.q = {3'h0, q_inc};
            n.trap_call = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (link) begin
          n.st = ST_CONN;
        end else if (s.dly == 10'h000) begin
          n.st = ST_DIAL;
          n.call_req = 1'b1;
        end
      end
      ST_CONN: begin
        if (!link) begin
          // spacing between successive dial-outs
          n.st = ST_IDLE;
          n.dly = dly_load; // [R13]
          n.trap_call = 1'b0;
          n.backup = 1'b0;
          n.dir = 3'h0; // [R15]
        end
      end
    endcase
    // cut-off holds until every cause clears; a new cut-off wins
    if (cut_cmd) begin
      n.cutoff = 1'b1; // [R21]
    end else if (!any_alarm) begin
      n.cutoff = 1'b0; // [R21]
    end
    n.relay = s.cfg.shared_relay_enable & any_alarm & ~n.cutoff; // [R20]
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.cfg <= adm_cfg_t'(CFG_RESET);
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  // every output is a flop of the state
  assign wb_dat_r = s.dat;
  assign wb_ack = s.ack;
  assign call_req = s.call_req;
  assign call_dir = s.dir;
  assign hangup = s.hang;
  assign alarm_modem = s.alm_modem;
  assign alarm_com = s.alm_com;
  assign trap_send = s.trap;
  assign trap_fwd = s.fwd;
  assign relay = s.relay;
endmodule // adm_top
`default_nettype wire

// ===== sim/adm_checker.sv
// port assertions for the alarm, dial-out and error monitor
`default_nettype none
module adm_checker import adm_pkg::*; #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic wb_ack,
  // dialler, messages and relay
  input wire logic call_req,
  input wire logic [2:0] call_dir,
  input wire logic hangup,
  input wire logic alarm_modem,
  input wire logic alarm_com,
  input wire logic trap_send,
  input wire logic trap_fwd,
  input wire logic relay
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cfg_q;
  logic [19:0] gap_q;
  logic seen_q;
  logic wr;
  logic cmd_wr;
  logic post;
  logic disc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // writes decoded at the edge that takes them
  assign wr = wb_cyc && wb_stb && wb_we && wb_ack;
  assign cmd_wr = wr && wb_adr == OFS_CMD;
  assign post = cmd_wr && wb_sel[0] && wb_dat_w[3:0] != 4'h0;
  assign disc = cmd_wr && wb_sel[1] && wb_dat_w[CMD_DISC];
  // shadow of the config word, byte lanes as the bus writes them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= CFG_RESET;
    end else if (wr && wb_adr == OFS_CFG) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel[i]) cfg_q[8*i +: 8] <= wb_dat_w[8*i +: 8];
      end
    end
  end
  // idle cycles since the last attempt; saturates so it never wraps
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q <= 20'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= call_req ? 20'h0 : gap_q + 20'(gap_q != 20'hfffff);
      seen_q <= seen_q | call_req;
    end
  end
  com_route_a: assert property (
    alarm_com == $past(post && cfg_q[1] && cfg_q[2])) else $error("com alarm mismatch");
  modem_route_a: assert property (
    alarm_modem |-> $past(cfg_q[0])) else $error("modem alarm with modem route off");
  own_trap_a: assert property (
    trap_send |-> $past(cfg_q[3])) else $error("own trap sent while traps disabled");
  fwd_trap_a: assert property (
    trap_fwd == $past(cmd_wr && wb_sel[1] && wb_dat_w[CMD_FWD_TRAP] && (cfg_q[3] || cfg_q[4])))
    else $error("forwarded trap mismatch");
  dial_gate_a: assert property (
    $rose(call_req) |-> $past(cfg_q[6])) else $error("dial with auto calling off");
  backup_dir_a: assert property (
    call_req && call_dir != 3'h0 |-> call_dir == cfg_q[14:12] && cfg_q[7]) else $error("bad directory");
  dial_gap_a: assert property (
    $rose(call_req) && seen_q |-> gap_q >= (cfg_q[11:8] * 60 - 1) * TICK_CYCLES)
    else $error("redial before dial delay");
  hangup_a: assert property (
    hangup |-> $past(cfg_q[5]) || $past(disc) || $past(disc, 2)) else $error("unexpected hangup");
  cutoff_a: assert property (
    cmd_wr && wb_sel[1] && wb_dat_w[CMD_CUTOFF] |-> ##[1:3] !relay) else $error("relay kept after cut-off");
  relay_gate_a: assert property (
    relay |-> $past(cfg_q[18])) else $error("relay driven while disabled");
endmodule // adm_checker
bind adm_top adm_checker #(.TICK_CYCLES(TICK_CYCLES)) adm_checker_i (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
  .wb_ack(wb_ack), .call_req(call_req), .call_dir(call_dir), .hangup(hangup), .alarm_modem(alarm_modem),
  .alarm_com(alarm_com), .trap_send(trap_send), .trap_fwd(trap_fwd), .relay(relay));
`default_nettype wire

// ===== sim/adm_modem.sv
// far-side dialler model: refuses a set number of attempts, then answers
`default_nettype none
module adm_modem (
  // clock and monitor side
  input wire logic clk,
  input wire logic call_req,
  input wire logic hangup,
  // bench control
  input wire logic [3:0] fails,
  input wire logic drop,
  input wire logic remote_open,
  // line state
  output logic link_up,
  output logic call_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_q = 0;
  int t_q = 0;
  logic ring_q = 1'b0;
  // each attempt rings a few cycles; a refusal is held long enough to cross the synchroniser
  always @(posedge clk) begin
    if (t_q > 0) t_q <= t_q - 1;
    if (call_req === 1'b1 && !ring_q && !call_fail && !link_up) begin
      ring_q <= 1'b1;
      t_q <= 8;
    end
    if (ring_q && t_q == 1) begin
      ring_q <= 1'b0;
      if (n_q < int'(fails)) begin
        call_fail <= 1'b1;
        n_q <= n_q + 1;
        t_q <= 6;
      end else begin
        link_up <= 1'b1;
      end
    end
    if (call_fail && t_q == 1) call_fail <= 1'b0;
    if (hangup === 1'b1 || drop) link_up <= 1'b0;
    if (drop) n_q <= 0;
    if (remote_open) link_up <= 1'b1;
  end
  initial begin
    link_up = 1'b0;
    call_fail = 1'b0;
  end
endmodule // adm_modem
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the alarm monitor
`default_nettype none
module tb;
  import adm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] cfg; logic [15:0] cmd; logic [2:0] exp;} adm_row_t;
  logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, link_up, call_fail, call_req, hangup, creq_q;
  logic alarm_modem, alarm_com, trap_send, trap_fwd, relay, drop, ropen;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, fails;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [2:0] call_dir, dir0;
  logic [1:0] crc_err;
  adm_line_t line_cond;
  int failures = 0, checks = 0, n_mod = 0, n_com = 0, n_fwd = 0, n_trap = 0, n_dial = 0, s, m;
  // rows: config, command, expected {modem, com, forward} pulses; no link, auto calling off
  adm_row_t rows [5] = '{'{32'h10c, 16'h203, 3'h1}, '{32'h106, 16'h203, 3'h2}, '{32'h102, 16'h003, 3'h0},
    '{32'h117, 16'h203, 3'h3}, '{32'h101, 16'h003, 3'h0}};
  adm_top #(.TICK_CYCLES(10)) adm_top_i (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .line_cond(line_cond), .crc_err(crc_err), .link_up(link_up), .call_fail(call_fail),
    .call_req(call_req), .call_dir(call_dir), .hangup(hangup), .alarm_modem(alarm_modem),
    .alarm_com(alarm_com), .trap_send(trap_send), .trap_fwd(trap_fwd), .relay(relay));
  adm_modem adm_modem_i (.clk(clk), .call_req(call_req), .hangup(hangup), .fails(fails), .drop(drop),
    .remote_open(ropen), .link_up(link_up), .call_fail(call_fail));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // pulse tallies sample the registered outputs at the edge
  always @(posedge clk) begin
    creq_q <= call_req;
    n_mod <= n_mod + int'(alarm_modem);
    n_com <= n_com + int'(alarm_com);
    n_fwd <= n_fwd + int'(trap_fwd);
    n_trap <= n_trap + int'(trap_send);
    if (call_req === 1'b1 && creq_q !== 1'b1) begin
      n_dial <= n_dial + 1;
      dir0 <= call_dir;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one classic cycle; held until ack is sampled, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    chk("ack", 32'(wb_ack), 32'h1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse_drop();
    drop <= 1'b1;
    @(posedge clk);
    drop <= 1'b0;
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      crc_err <= 2'h1;
      wt(4);
      crc_err <= 2'h0;
      wt(4);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hang costs one mismatch
  initial begin
    wt(40000);
    failures++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, drop, ropen} = 5'h0;
    wb_adr = 8'h0;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0;
    line_cond = '0;
    crc_err = 2'h0;
    fails = 4'h0;
    wt(2);
    sys_rst <= 1'b0;
    wt(1);
    bus(1'b0, OFS_CFG, 32'h0);
    chk("cfg reset", rd, CFG_RESET);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", rd, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, OFS_CFG, rows[i].cfg);
      s = n_mod * 4 + n_com * 2 + n_fwd;
      bus(1'b1, OFS_CMD, 32'(rows[i].cmd));
      wt(2);
      chk("route", 32'(n_mod * 4 + n_com * 2 + n_fwd - s), 32'(rows[i].exp));
    end
    // trap queue: refused while disabled, fills to depth, drains on a link
    bus(1'b1, OFS_CFG, 32'h100);
    bus(1'b1, OFS_CMD, 32'h100);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("queue off", 32'(rd[11:8]), 32'h0);
    bus(1'b1, OFS_CFG, 32'h108);
    repeat (12) bus(1'b1, OFS_CMD, 32'h100);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("queue full", 32'(rd[11:8]), 32'(TRAP_QUEUE_DEPTH));
    s = n_trap;
    ropen <= 1'b1;
    wt(1);
    ropen <= 1'b0;
    wt(30);
    chk("traps sent", 32'(n_trap - s), 32'(TRAP_QUEUE_DEPTH));
    // ten refusals: five retries on the alarm number, then the backup answers on its fifth try
    fails <= 4'ha;
    pulse_drop();
    bus(1'b1, OFS_CFG, 32'h31e1);
    s = n_dial;
    m = n_mod;
    bus(1'b1, OFS_CMD, 32'h2);
    wt(700);
    bus(1'b1, OFS_CMD, 32'h5);
    bus(1'b1, OFS_CMD, 32'h3);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("held prio", 32'(rd[7:4]), 32'h5);
    for (int n = 0; n < 20000 && link_up !== 1'b1; n++) wt(1);
    wt(10);
    chk("attempts", 32'(n_dial - s), 32'd11);
    chk("backup dir", 32'(dir0), 32'h3);
    chk("alarm sent", 32'(n_mod - m), 32'h1);
    // never answered: one try with retry off, six with it on
    bus(1'b1, OFS_CMD, 32'h800);
    wt(1);
    chk("disconnect", 32'(link_up), 32'h0);
    fails <= 4'hf;
    pulse_drop();
    bus(1'b1, OFS_CFG, 32'h161);
    s = n_dial;
    bus(1'b1, OFS_CMD, 32'h1);
    wt(2500);
    chk("one try", 32'(n_dial - s), 32'h1);
    chk("first dir", 32'(dir0), 32'h0);
    bus(1'b1, OFS_CFG, 32'h1e1);
    s = n_dial;
    bus(1'b1, OFS_CMD, 32'h1);
    wt(5000);
    chk("retry cap", 32'(n_dial - s), 32'h6);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("give up", 32'({rd[19:16], rd[7:4]}), 32'h10);
    // each line condition alone, then cut-off held until all clear
    bus(1'b1, OFS_CFG, 32'h40100);
    for (int i = 0; i < 7; i++) begin
      line_cond <= adm_line_t'(7'h1 << i);
      wt(8);
      chk("relay on", 32'(relay), 32'h1);
      line_cond <= '0;
      wt(8);
      chk("relay off", 32'(relay), 32'h0);
    end
    line_cond <= adm_line_t'(7'h01);
    wt(8);
    bus(1'b1, OFS_CMD, 32'h400);
    line_cond <= adm_line_t'(7'h03);
    wt(8);
    chk("cut off", 32'(relay), 32'h0);
    line_cond <= '0;
    wt(8);
    line_cond <= adm_line_t'(7'h01);
    wt(8);
    chk("rearm", 32'(relay), 32'h1);
    line_cond <= '0;
    // lowest rate: more than four errors across the three intervals
    bus(1'b1, OFS_CFG, 32'h68100);
    errs(4);
    wt(4);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("eer below", 32'(rd[1:0]), 32'h0);
    errs(1);
    wt(4);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("eer set", 32'(|rd[1:0]), 32'h1);
    chk("eer relay", 32'(relay), 32'h1);
    bus(1'b1, OFS_CFG, 32'h58100);
    wt(700);
    errs(9);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("e7 below", 32'(rd[1:0]), 32'h0);
    errs(1);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("e7 set", 32'(rd[0]), 32'h1);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
